//--- shared/secfg_pkg.sv
// Constants, register map and state codes of the EEPROM config autoloader
// What this block does
// - Org strap picks word or byte EEPROM access
// - Load runs by itself at reset, no host
// - First EEPROM location is checked as signature
// - Load starts after reset if signature and RTS ok
// - Word 0Ah bit0 loads offset 80h bit21
// - Word 0Ah bits3:1 load aux current 80h[24:22]
// - Word 0Ah bits4,5 load D1/D2 support flags
// - Word 0Ah bits10:6 load event support 80h[31:27]
// - Word 0Ah bit11 loads no-soft-reset 84h bit3
// - Word 10h loads ASPM and exit latencies ECh
// - Words 12h/14h load transceiver modes at B4h
// - Word 16h loads B8h bits 21:16
// - Word 1Ah bit0 loads error report enable C4h[15]
// - Word 1Ah bits15:8 load capability pointer 34h
// - Word 1Ch bits7:0 load revision ID 08h
// - Seven-bit word address in 16-bit organization, eight-bit byte address in 8-bit
// - Serial pins read a 2K-bit serial EEPROM
package secfg_pkg;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int SCK_HALF_NS    = 500;
  localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int STRAP_WAIT_CYC = 4;
  localparam logic [2:0] EE_READ_CMD = 3'h6;
  localparam int NUM_STEPS      = 8;
  // EEPROM byte addresses, signature first
  localparam logic [7:0] EE_ADDR [NUM_STEPS] = '{8'h00, 8'h0A, 8'h10,
    8'h12, 8'h14, 8'h16, 8'h1A, 8'h1C};
  // Field reset values
  localparam logic [10:0] PM80_RST = 11'h23E;
  localparam logic        NSR84_RST = 1'h1;
  localparam logic [7:0]  ASPM_RST = 8'h0F;
  localparam logic [31:0] XCVR_RST = 32'h00000000;
  localparam logic [5:0]  PMC_RST  = 6'h01;
  localparam logic        RBER_RST = 1'h1;
  localparam logic [7:0]  CAP_RST  = 8'h80;
  localparam logic [7:0]  REV_RST  = 8'h00;
  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG08  = 8'h08;
  localparam logic [7:0] REG_CFG34  = 8'h0C;
  localparam logic [7:0] REG_CFG80  = 8'h10;
  localparam logic [7:0] REG_CFG84  = 8'h14;
  localparam logic [7:0] REG_CFGB4  = 8'h18;
  localparam logic [7:0] REG_CFGB8  = 8'h1C;
  localparam logic [7:0] REG_CFGC4  = 8'h20;
  localparam logic [7:0] REG_CFGEC  = 8'h24;
  localparam logic [7:0] CTRL_RST   = 8'(SCK_HALF_CYC);
  typedef enum logic [2:0] {
    S_WAIT  = 3'b000,
    S_GAP   = 3'b001,
    S_XFER  = 3'b010,
    S_STORE = 3'b011,
    S_DONE  = 3'b100
  } secfg_state_t;
endpackage : secfg_pkg

//--- src/secfg_loader.sv
// Serial EEPROM configuration autoloader with APB status access
`timescale 1ns/1ns
module secfg_loader
  import secfg_pkg::*;
#(
  parameter logic [15:0] SIGNATURE = 16'h5AA5 // Arbitrary value
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_eeprom_org_select_n,
  input  wire logic        i_uart0_rts_n,
  input  wire logic        i_eeprom_serial_out,
  output logic             o_eeprom_serial_in,
  output logic             o_eeprom_chip_select,
  output logic             o_eeprom_serial_clock_out,
  output logic             o_eeprom_org_word,
  output logic             o_cfg_ready,
  output logic [31:0]      o_cfg_08,
  output logic [31:0]      o_cfg_34,
  output logic [31:0]      o_cfg_80,
  output logic [31:0]      o_cfg_84,
  output logic [31:0]      o_cfg_b4,
  output logic [31:0]      o_cfg_b8,
  output logic [31:0]      o_cfg_c4,
  output logic [31:0]      o_cfg_ec,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr
);
  secfg_state_t st_q;
  logic [2:0]  org_s_q, rts_s_q, do_s_q;
  logic [2:0]  wait_q;
  logic        word_q, rts_blk_q, sig_ok_q;
  logic [7:0]  div_q, ctrl_q;
  logic        tick;
  logic [2:0]  step_q;
  logic        half_q;
  logic [4:0]  bit_q;
  logic [10:0] cmd_q;
  logic [15:0] sh_q;
  logic [7:0]  lo_q;
  logic        sck_q, cs_q, di_q;
  logic [4:0]  cmd_len, total_len;
  logic [7:0]  byte_addr;
  logic [15:0] wd;
  logic        word_ready;
  logic [10:0] pm80_q;
  logic        nsr84_q, rber_q;
  logic [7:0]  aspm_q, cap_q, rev_q;
  logic [31:0] xcvr_q;
  logic [5:0]  pmc_q;
  logic        apb_setup, apb_wr, addr_ok;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      org_s_q <= 3'h7;
      rts_s_q <= 3'h7;
      do_s_q  <= 3'h0;
    end else begin
      org_s_q <= {org_s_q[1:0], i_eeprom_org_select_n};
      rts_s_q <= {rts_s_q[1:0], i_uart0_rts_n};
      do_s_q  <= {do_s_q[1:0], i_eeprom_serial_out};
    end
  end

  // Serial clock half-period enable
  always_ff @(posedge i_clk) begin
    if (i_reset || st_q == S_WAIT || st_q == S_DONE) begin
      div_q <= 8'h00;
    end else if (tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = (div_q + 8'h01 >= ctrl_q);

  assign cmd_len    = word_q ? 5'h0A : 5'h0B;
  assign total_len  = cmd_len + (word_q ? 5'h11 : 5'h09);
  assign byte_addr  = EE_ADDR[step_q] + {7'h00, half_q};
  assign word_ready = word_q || half_q;
  assign wd         = word_q ? sh_q : {sh_q[7:0], lo_q};

  // Sequencer: strap capture, reads, signature check
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q      <= S_WAIT;
      wait_q    <= 3'h0;
      word_q    <= 1'b0;
      rts_blk_q <= 1'b0;
      sig_ok_q  <= 1'b0;
      step_q    <= 3'h0;
      half_q    <= 1'b0;
      bit_q     <= 5'h00;
      cmd_q     <= 11'h000;
      sh_q      <= 16'h0000;
      lo_q      <= 8'h00;
      sck_q     <= 1'b0;
      cs_q      <= 1'b0;
      di_q      <= 1'b0;
    end else begin
      unique case (st_q)
        S_WAIT: begin
          if (wait_q != 3'(STRAP_WAIT_CYC)) begin
            wait_q <= wait_q + 3'h1;
          end else if (org_s_q[2] == org_s_q[1] &&
                       rts_s_q[2] == rts_s_q[1]) begin
            word_q    <= ~org_s_q[2];
            rts_blk_q <= ~rts_s_q[2];
            st_q      <= rts_s_q[2] ? S_GAP : S_DONE;
          end
        end
        S_GAP: begin
          if (tick) begin
            cs_q  <= 1'b1;
            di_q  <= 1'b1;
            bit_q <= 5'h00;
            cmd_q <= word_q ? {EE_READ_CMD, byte_addr[7:1], 1'b0}
                            : {EE_READ_CMD, byte_addr};
            st_q  <= S_XFER;
          end
        end
        S_XFER: begin
          if (tick && !sck_q) begin
            sck_q <= 1'b1;
            if (bit_q >= cmd_len) begin
              sh_q <= {sh_q[14:0], do_s_q[2]};
            end
          end else if (tick) begin
            sck_q <= 1'b0;
            bit_q <= bit_q + 5'h01;
            cmd_q <= {cmd_q[9:0], 1'b0};
            di_q  <= cmd_q[9];
            if (bit_q + 5'h01 == total_len) begin
              cs_q <= 1'b0;
              di_q <= 1'b0;
              st_q <= S_STORE;
            end
          end
        end
        S_STORE: begin
          if (!word_ready) begin
            lo_q   <= sh_q[7:0];
            half_q <= 1'b1;
            st_q   <= S_GAP;
          end else begin
            half_q <= 1'b0;
            if (step_q == 3'h0 && wd != SIGNATURE) begin
              st_q <= S_DONE;
            end else if (step_q == 3'(NUM_STEPS - 1)) begin
              st_q <= S_DONE;
            end else begin
              if (step_q == 3'h0) begin
                sig_ok_q <= 1'b1;
              end
              step_q <= step_q + 3'h1;
              st_q   <= S_GAP;
            end
          end
        end
        S_DONE: begin
          cs_q  <= 1'b0;
          sck_q <= 1'b0;
        end
      endcase
    end
  end

  // Configuration fields, loaded from EEPROM words
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pm80_q  <= PM80_RST;
      nsr84_q <= NSR84_RST;
      aspm_q  <= ASPM_RST;
      xcvr_q  <= XCVR_RST;
      pmc_q   <= PMC_RST;
      rber_q  <= RBER_RST;
      cap_q   <= CAP_RST;
      rev_q   <= REV_RST;
    end else if (st_q == S_STORE && word_ready) begin
      unique case (step_q)
        3'h1: begin
          pm80_q  <= wd[10:0];
          nsr84_q <= wd[11];
        end
        3'h2: aspm_q <= wd[7:0];
        3'h3: xcvr_q[15:0] <= wd;
        3'h4: xcvr_q[31:16] <= wd;
        3'h5: pmc_q <= wd[5:0];
        3'h6: begin
          rber_q <= wd[0];
          cap_q  <= wd[15:8];
        end
        3'h7: rev_q <= wd[7:0];
        default: begin
        end
      endcase
    end
  end

  assign o_eeprom_serial_in        = di_q;
  assign o_eeprom_chip_select      = cs_q;
  assign o_eeprom_serial_clock_out = sck_q;
  assign o_eeprom_org_word         = word_q;
  assign o_cfg_ready = (st_q == S_DONE);
  assign o_cfg_08 = {24'h000000, rev_q};
  assign o_cfg_34 = {24'h000000, cap_q};
  assign o_cfg_80 = {pm80_q, 21'h000000};
  assign o_cfg_84 = {28'h0000000, nsr84_q, 3'h0};
  assign o_cfg_b4 = xcvr_q;
  assign o_cfg_b8 = {10'h000, pmc_q, 16'h0000};
  assign o_cfg_c4 = {16'h0000, rber_q, 15'h0000};
  assign o_cfg_ec = {14'h0000, aspm_q, 10'h000};

  // APB slave: zero wait, read data captured in setup phase
  assign apb_setup = i_psel && !i_penable;
  assign apb_wr    = i_psel && i_penable && i_pwrite;
  assign addr_ok   = (i_paddr[31:8] == 24'h000000) &&
                     (i_paddr[1:0] == 2'h0) && (i_paddr[7:0] <= REG_CFGEC);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_q <= CTRL_RST;
    end else if (apb_wr && i_paddr == {24'h000000, REG_CTRL} &&
                 i_pwdata[7:0] != 8'h00) begin
      ctrl_q <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_prdata <= 32'h00000000;
    end else if (apb_setup) begin
      if (!addr_ok) begin
        o_prdata <= 32'h00000000;
      end else begin
        unique case (i_paddr[7:0])
          REG_CTRL:   o_prdata <= {24'h000000, ctrl_q};
          REG_STATUS: o_prdata <= {28'h0000000, word_q, rts_blk_q,
                                   sig_ok_q, o_cfg_ready};
          REG_CFG08:  o_prdata <= o_cfg_08;
          REG_CFG34:  o_prdata <= o_cfg_34;
          REG_CFG80:  o_prdata <= o_cfg_80;
          REG_CFG84:  o_prdata <= o_cfg_84;
          REG_CFGB4:  o_prdata <= o_cfg_b4;
          REG_CFGB8:  o_prdata <= o_cfg_b8;
          REG_CFGC4:  o_prdata <= o_cfg_c4;
          REG_CFGEC:  o_prdata <= o_cfg_ec;
          default:    o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Checks
  sequence s_store(logic [2:0] n);
    st_q == S_STORE && word_ready && step_q == n;
  endsequence

  // Both straps settled and the start-up wait elapsed
  sequence s_capture;
    st_q == S_WAIT && wait_q == 3'(STRAP_WAIT_CYC) &&
      org_s_q[2] == org_s_q[1] && rts_s_q[2] == rts_s_q[1];
  endsequence

  a_org_held: assert property (@(posedge i_clk) disable iff (i_reset)
    st_q != S_WAIT |=> $stable(word_q) &&
      cmd_len == (word_q ? 5'h0A : 5'h0B))
    else $error("organization changed after start-up");
  a_start_bit: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(cs_q) |-> di_q && !sck_q ##1 cs_q && di_q)
    else $error("read does not open with start bit");
  a_sig_gate: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h0) and (wd != SIGNATURE) |=> st_q == S_DONE && !sig_ok_q)
    else $error("bad signature did not stop the load");
  a_rts_block: assert property (@(posedge i_clk) disable iff (i_reset)
    rts_blk_q |-> !cs_q && xcvr_q == XCVR_RST && pm80_q == PM80_RST)
    else $error("load ran while strap blocked it");
  a_done_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
    st_q == S_DONE |=> !cs_q && !sck_q && st_q == S_DONE)
    else $error("EEPROM accessed after load finished");
  a_pm_load: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h1) |=> pm80_q == $past(wd[10:0]) && nsr84_q == $past(wd[11]))
    else $error("power management word not loaded");
  a_aspm_load: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h2) |=> o_cfg_ec[17:10] == $past(wd[7:0]))
    else $error("link state word not loaded");
  a_xcvr_load: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h4) |=> xcvr_q[31:16] == $past(wd))
    else $error("transceiver high half not loaded");
  a_cap_load: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h6) |=> o_cfg_34[7:0] == $past(wd[15:8]) &&
      rber_q == $past(wd[0]))
    else $error("capability pointer not loaded");
  a_rev_ready: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h7) |=> o_cfg_08[7:0] == $past(wd[7:0]) && o_cfg_ready)
    else $error("revision not loaded before ready");
  a_ready_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_cfg_ready) |-> !cs_q &&
      step_q == (sig_ok_q ? 3'(NUM_STEPS - 1) : 3'h0))
    else $error("ready raised before the map was loaded");
  a_org_capture: assert property (@(posedge i_clk) disable iff (i_reset)
    s_capture |=> word_q == !$past(org_s_q[2]))
    else $error("organization strap not captured");
  a_rts_sample: assert property (@(posedge i_clk) disable iff (i_reset)
    s_capture |=> (st_q == S_GAP) == $past(rts_s_q[2]))
    else $error("load start does not follow the strap");
  a_xcvr_low: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h3) |=> xcvr_q[15:0] == $past(wd))
    else $error("transceiver low half not loaded");
  a_pmc_load: assert property (@(posedge i_clk) disable iff (i_reset)
    s_store(3'h5) |=> o_cfg_b8[21:16] == $past(wd[5:0]))
    else $error("power control word not loaded");
  a_sk_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    !cs_q |-> !sck_q)
    else $error("serial clock high outside a frame");
  a_di_stable: assert property (@(posedge i_clk) disable iff (i_reset)
    sck_q |-> $stable(di_q))
    else $error("serial data changed while clock high");

  // Counts serial clock rising edges within one chip-select frame
  logic [4:0]  sk_rise_q;
  logic        sck_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sck_prev_q <= 1'b0;
      sk_rise_q  <= 5'h00;
    end else begin
      sck_prev_q <= sck_q;
      if (!cs_q) begin
        sk_rise_q <= 5'h00;
      end else if (sck_q && !sck_prev_q) begin
        sk_rise_q <= sk_rise_q + 5'h01;
      end
    end
  end

  a_frame_len: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(cs_q) |-> sk_rise_q == (word_q ? 5'h1B : 5'h14))
    else $error("read frame has a wrong clock count");
endmodule : secfg_loader

//--- testbench/secfg_eeprom_model.sv
// Behavioural serial configuration EEPROM of 128 words
`timescale 1ns/1ns
module secfg_eeprom_model (
  input  wire logic i_cs,
  input  wire logic i_sk,
  input  wire logic i_di,
  input  wire logic i_word,
  output logic      o_do
);
  logic [15:0] mem [128];
  logic [10:0] cmd = 11'h0;
  logic        ok;
  int          cnt;
  int          nb;
  int          k;
  int          addr_q [$];
  initial o_do = 1'b0;
  // Released line shows the inverse of its last bit
  always @(negedge i_cs) begin
    cnt = 0;
    o_do = ~o_do;
  end
  always @(posedge i_sk) begin
    if (i_cs) begin
      cnt++;
      nb = i_word ? 10 : 11;
      k = cnt - nb - 1;
      if (cnt <= nb) cmd = {cmd[9:0], i_di};
      ok = i_word ? (cmd[9:7] == 3'h6) : (cmd[10:8] == 3'h6);
      if (cnt == nb) begin
        addr_q.push_back(i_word ? int'(cmd[6:0]) : int'(cmd[7:0]));
        o_do = ok ? 1'b0 : ~o_do;
      end else if (cnt > nb && ok && k < (i_word ? 16 : 8)) begin
        o_do = i_word ? mem[cmd[6:0]][15-k]
                      : mem[cmd[7:1]][{cmd[0], 3'(7-k)}];
      end else if (cnt > nb) begin
        o_do = ~o_do;
      end
    end
  end
endmodule : secfg_eeprom_model

//--- testbench/tb_top.sv
// Self-checking bench of the EEPROM configuration autoloader
`timescale 1ns/1ns
module tb_top;
  import secfg_pkg::*;
  localparam logic [15:0] SIG = 16'h5AA5; // Arbitrary value
  logic        i_clk = 1'b0, i_reset = 1'b1;
  logic        i_eeprom_org_select_n = 1'b0, i_uart0_rts_n = 1'b1;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0;
  logic        i_eeprom_serial_out, o_eeprom_serial_in, o_eeprom_chip_select;
  logic        o_eeprom_serial_clock_out, o_eeprom_org_word, o_cfg_ready;
  logic [31:0] o_cfg_08, o_cfg_34, o_cfg_80, o_cfg_84, o_prdata;
  logic [31:0] o_cfg_b4, o_cfg_b8, o_cfg_c4, o_cfg_ec;
  logic        o_pready, o_pslverr;
  int          error_cnt = 0, n_checks = 0, cyc = 0, seed = 92, n_cs = 0;
  always #25 i_clk = ~i_clk;
  always @(posedge o_eeprom_chip_select) n_cs++;
  secfg_loader #(.SIGNATURE(SIG)) DUT (.i_clk, .i_reset,
    .i_eeprom_org_select_n, .i_uart0_rts_n, .i_eeprom_serial_out,
    .o_eeprom_serial_in, .o_eeprom_chip_select, .o_eeprom_serial_clock_out,
    .o_eeprom_org_word, .o_cfg_ready, .o_cfg_08, .o_cfg_34, .o_cfg_80,
    .o_cfg_84, .o_cfg_b4, .o_cfg_b8, .o_cfg_c4, .o_cfg_ec, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata,
    .o_pslverr);
  secfg_eeprom_model EE (.i_cs(o_eeprom_chip_select),
    .i_sk(o_eeprom_serial_clock_out), .i_di(o_eeprom_serial_in),
    .i_word(!i_eeprom_org_select_n), .o_do(i_eeprom_serial_out));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1 && cyc < 60000);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic run(input logic wd, input logic rts, input logic [15:0] sg);
    logic [15:0] w [8];
    logic [31:0] ex [8];
    logic [31:0] gt [8];
    logic [31:0] r;
    logic        e;
    logic        ok;
    int          q [$];
    int          t;
    @(posedge i_clk);
    i_reset <= 1'b1;
    i_eeprom_org_select_n <= !wd;
    i_uart0_rts_n <= rts;
    for (int i = 0; i < 128; i++) EE.mem[i] = 16'($random(seed));
    EE.mem[0] = sg;
    EE.addr_q.delete();
    repeat (12) @(posedge i_clk);
    n_cs = 0;
    i_reset <= 1'b0;
    t = 0;
    while (o_cfg_ready !== 1'b1 && t < 20000) begin
      @(posedge i_clk);
      t++;
    end
    chk(32'(o_cfg_ready), 32'h1);
    chk(32'(n_cs), 32'(ok_cnt(wd, rts, sg === SIG)));
    ok = (sg === SIG) && rts;
    for (int i = 0; i < 8; i++) w[i] = EE.mem[EE_ADDR[i] >> 1];
    if (!ok) w = '{16'h0, 16'h0A3E, 16'h000F, 16'h0, 16'h0, 16'h0001,
                   16'h8001, 16'h0000};
    ex = '{{24'h0, w[7][7:0]}, {24'h0, w[6][15:8]}, {w[1][10:0], 21'h0},
      {28'h0, w[1][11], 3'h0}, {w[4], w[3]}, {10'h0, w[5][5:0], 16'h0},
      {16'h0, w[6][0], 15'h0}, {14'h0, w[2][7:0], 10'h0}};
    gt = '{o_cfg_08, o_cfg_34, o_cfg_80, o_cfg_84, o_cfg_b4, o_cfg_b8,
           o_cfg_c4, o_cfg_ec};
    for (int i = 0; i < 8; i++) begin
      chk(gt[i], ex[i]);
      apb(1'b1, 32'(8 + 4 * i), 32'($random(seed)), r, e);
      apb(1'b0, 32'(8 + 4 * i), 32'h0, r, e);
      chk(r, ex[i]);
    end
    apb(1'b0, 32'h4, 32'h0, r, e);
    chk(r & 32'hD, {28'h0, wd, !rts, 1'b0, 1'b1});
    if (rts) chk(32'(r[1]), 32'(sg === SIG));
    chk(32'(o_eeprom_org_word), 32'(wd));
    for (int i = 0; i < (ok ? 8 : (rts ? 1 : 0)); i++) begin
      q.push_back(wd ? EE_ADDR[i] >> 1 : EE_ADDR[i]);
      if (!wd) q.push_back(EE_ADDR[i] + 8'h01);
    end
    repeat (400) @(posedge i_clk);
    chk(32'(n_cs), 32'(q.size()));
    chk(32'(EE.addr_q.size()), 32'(q.size()));
    foreach (q[i])
      if (i < EE.addr_q.size()) chk(32'(EE.addr_q[i]), 32'(q[i]));
  endtask : run
  function automatic int ok_cnt(logic wd, logic rts, logic sok);
    return !rts ? 0 : (wd ? (sok ? 8 : 1) : (sok ? 16 : 2));
  endfunction : ok_cnt
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    logic [31:0] r;
    logic        e;
    logic [31:0] bad [3];
    bad = '{32'h28, 32'h09, 32'h100};
    run(1'b1, 1'b1, SIG);
    apb(1'b1, 32'h0, 32'h0, r, e);
    apb(1'b0, 32'h0, 32'h0, r, e);
    chk(r, 32'h0000000A);
    chk(32'(e), 32'h0);
    foreach (bad[i]) begin
      apb(1'b0, bad[i], 32'h0, r, e);
      chk(32'(e), 32'h1);
      chk(r, 32'h0);
    end
    apb(1'b1, 32'h0, 32'h3, r, e);
    apb(1'b0, 32'h0, 32'h0, r, e);
    chk(r, 32'h3);
    run(1'b0, 1'b1, SIG);
    run(1'b1, 1'b1, ~SIG);
    run(1'b0, 1'b1, SIG ^ 16'h0100);
    run(1'b1, 1'b0, SIG);
    final_report();
  end
endmodule : tb_top
